// File: rtl/asids_map.svh
// constants of the adapter setup id sequencer
`ifndef ASIDS_MAP_SVH
`define ASIDS_MAP_SVH
// ----------------------------------------
// option register selects on address bits 2..0
// ----------------------------------------
`define ASIDS_SEL_ID_LO 3'h0
`define ASIDS_SEL_ID_HI 3'h1
`define ASIDS_SEL_ENABLE 3'h2
`define ASIDS_ENABLE_BIT 0
`define ASIDS_RST_DATA 8'h00
`define ASIDS_RST_EN 1'b0
`define ASIDS_RST_SYNC 9'h000
`endif

// File: rtl/asids_pkg.sv
// types of the adapter setup id sequencer
package asids_pkg;
    typedef enum logic [2:0]
    {
        ASIDS_IDLE = 3'b000,
        ASIDS_ARM_LO = 3'b001,
        ASIDS_SEND_LO = 3'b010,
        ASIDS_ARM_HI = 3'b011,
        ASIDS_SEND_HI = 3'b100,
        ASIDS_REST = 3'b101
    } asids_state_t;
endpackage

// File: rtl/asids_seq.sv
// adapter setup id sequencer: id reads and enable bit during setup
`timescale 1ns/10ps
`default_nettype none
`include "asids_map.svh"

// Behaviour
// RL1 - all registers clear to zero at reset
// RL2 - idle waits for setup select active
// RL3 - setup select loads id low, wait read0
// RL4 - read of register 0 drives low id
// RL5 - read0 released, load id high byte
// RL6 - read of register 1 drives, enters S4
// RL7 - rest state during enable writes
// RL8 - enable bit from data line 0, separate
// RL9 - eight bit data, one enable, three state
// RL10 - register all bus control inputs first
// RL11 - accesses qualified by external decode input
// RL12 - address bits 2..0 pick option register
// RL13 - host reads ids, then writes 0, 1
// RL14 - host ends setup; one card only
// RL15 - setup inactive returns idle, enable kept
// RL16 - data outputs enabled only on id reads
module asids_seq #(
    parameter logic [7:0] ID_LO = 8'h5A, // arbitrary id low byte
    parameter logic [7:0] ID_HI = 8'h3C  // arbitrary id high byte
) (
    input wire logic mclk_i,                        // 100 MHz clock
    input wire logic rst_n_i,                       // async reset, low
    input wire logic card_setup_select_n_i,         // setup select, low
    input wire logic cmd_n_i,                       // bus command strobe, low
    input wire logic mem_io_i,                      // high memory, low io
    input wire logic bus_status_bit0_n_i,           // status 0, low = write
    input wire logic bus_status_bit1_n_i,           // status 1, low = read
    input wire logic [2:0] low_address_bits_i,      // address bits 2..0
    input wire logic decode_i,                      // upper address match
    input wire logic [7:0] data_lines_i,            // data bus in
    output logic [7:0] data_lines_o,                // data bus out
    output logic data_lines_oe_n_o,                 // low while driving
    output logic adapter_enable_out_o,              // adapter enabled
    output var asids_pkg::asids_state_t state_o     // sequencer state
);
    import asids_pkg::*;

    // ----------------------------------------
    // input capture
    // ----------------------------------------
    // pin inputs pass two flops; bus glitches must not reach the fsm
    logic [8:0] meta_q;
    logic [8:0] sync_q;
    logic [7:0] din_meta_q;
    logic [7:0] din_q;
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= `ASIDS_RST_SYNC;
            sync_q <= `ASIDS_RST_SYNC;
            din_meta_q <= `ASIDS_RST_DATA;
            din_q <= `ASIDS_RST_DATA;
        end
        else
        begin
            meta_q <= {~card_setup_select_n_i, ~cmd_n_i, mem_io_i, ~bus_status_bit0_n_i,
                       ~bus_status_bit1_n_i, low_address_bits_i, decode_i}; // see RL10
            sync_q <= meta_q;
            din_meta_q <= data_lines_i;
            din_q <= din_meta_q;
        end
    end

    logic setup_act;
    logic cmd_act;
    logic is_mem;
    logic wr_act;
    logic rd_act;
    logic [2:0] addr;
    logic dec;
    assign setup_act = sync_q[8];
    assign cmd_act = sync_q[7];
    assign is_mem = sync_q[6];
    assign wr_act = sync_q[5];
    assign rd_act = sync_q[4];
    assign addr = sync_q[3:1];
    assign dec = sync_q[0];

    // qualified io accesses to the option registers
    logic io_ok;
    logic rd0;
    logic rd1;
    logic wr2;
    assign io_ok = setup_act && cmd_act && !is_mem && dec; // see RL11
    assign rd0 = io_ok && rd_act && (addr == `ASIDS_SEL_ID_LO); // see RL12
    assign rd1 = io_ok && rd_act && (addr == `ASIDS_SEL_ID_HI); // see RL12
    assign wr2 = io_ok && wr_act && (addr == `ASIDS_SEL_ENABLE); // see RL12

    // ----------------------------------------
    // setup sequencer
    // ----------------------------------------
    asids_state_t state_q;
    asids_state_t state_d;
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ASIDS_IDLE: if (setup_act) state_d = ASIDS_ARM_LO; // see RL2
            ASIDS_ARM_LO: if (rd0) state_d = ASIDS_SEND_LO; // see RL3
            ASIDS_SEND_LO: if (!rd0) state_d = ASIDS_ARM_HI; // see RL4
            ASIDS_ARM_HI: if (rd1) state_d = ASIDS_SEND_HI; // see RL5
            ASIDS_SEND_HI: if (!rd1) state_d = ASIDS_REST; // see RL6
            ASIDS_REST: state_d = ASIDS_REST; // see RL7
            default: state_d = ASIDS_IDLE;
        endcase
        if (!setup_act)
        begin
            state_d = ASIDS_IDLE; // see RL15
        end
    end

    // three bit state register
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= ASIDS_IDLE; // see RL1
        end
        else
        begin
            state_q <= state_d; // see RL9
        end
    end
    assign state_o = state_q;

    // ----------------------------------------
    // id output register
    // ----------------------------------------
    // loaded on entry to each arm state, then held through the read
    logic [7:0] id_q;
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            id_q <= `ASIDS_RST_DATA; // see RL1
        end
        else if (state_d == ASIDS_ARM_LO)
        begin
            id_q <= ID_LO; // see RL3
        end
        else if (state_d == ASIDS_ARM_HI)
        begin
            id_q <= ID_HI; // see RL5
        end
    end
    assign data_lines_o = id_q;

    // drive only while a qualified id read is in its state
    assign data_lines_oe_n_o = !(((state_q == ASIDS_SEND_LO) && rd0) ||
                                 ((state_q == ASIDS_SEND_HI) && rd1)); // see RL16 see RL4 see RL6

    // ----------------------------------------
    // adapter enable bit
    // ----------------------------------------
    // separate from id_q although it shares data line 0
    logic enable_q;
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            enable_q <= `ASIDS_RST_EN; // see RL1
        end
        else if (wr2 && (state_q == ASIDS_REST))
        begin
            enable_q <= din_q[`ASIDS_ENABLE_BIT]; // see RL8
        end
    end
    assign adapter_enable_out_o = enable_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // one check per step of the id handshake except the read1 release into rest; rd0 and rd1 already imply setup_act
    sequence s_read0;
        (state_q == ASIDS_ARM_LO) && rd0;
    endsequence
    sequence s_into_send_lo;
        ##1 (state_q == ASIDS_SEND_LO);
    endsequence

    chk_idle_wait: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL2
        (state_q == ASIDS_IDLE) && !setup_act |=> (state_q == ASIDS_IDLE))
        else $error("idle left without setup");
    chk_setup_entry: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL3
        (state_q == ASIDS_IDLE) && setup_act |=> (state_q == ASIDS_ARM_LO) && (id_q == ID_LO))
        else $error("setup entry did not arm low id");
    chk_read0_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL4
        s_read0 |-> s_into_send_lo)
        else $error("read0 did not reach low send state");
    chk_lo_drive: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL3
        (state_q == ASIDS_SEND_LO) |-> (id_q == ID_LO))
        else $error("low id not loaded");
    chk_read0_done: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL5
        (state_q == ASIDS_SEND_LO) && !rd0 && setup_act |=> (state_q == ASIDS_ARM_HI) && (id_q == ID_HI))
        else $error("read0 release did not arm high id");
    chk_hi_drive: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL5
        (state_q == ASIDS_SEND_HI) |-> (id_q == ID_HI))
        else $error("high id not loaded");
    chk_read1_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL6
        (state_q == ASIDS_ARM_HI) && rd1 && setup_act |=> (state_q == ASIDS_SEND_HI))
        else $error("read1 did not reach high send state");
    chk_setup_exit: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL15
        !setup_act |=> (state_q == ASIDS_IDLE) && $stable(enable_q))
        else $error("setup exit wrong");
    chk_enable_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL8
        (state_q == ASIDS_REST) && wr2 |=> (enable_q == $past(din_q[`ASIDS_ENABLE_BIT])))
        else $error("enable bit not written");
    chk_oe_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL16
        !data_lines_oe_n_o |-> io_ok && rd_act && (addr[2:1] == 2'b00))
        else $error("data driven outside id read");
    chk_rest_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RL7
        (state_q == ASIDS_REST) && setup_act |=> (state_q == ASIDS_REST))
        else $error("rest state left during setup");
endmodule // asids_seq
`default_nettype wire

// File: tb/asids_host.sv
// host model that runs setup and option register cycles
`timescale 1ns/10ps
`default_nettype none
module asids_host (
    input wire logic clk_i, // bus clock
    output logic card_setup_select_n_o, // setup select
    output logic cmd_n_o, // command strobe
    output logic mem_io_o, // memory or io
    output logic bus_status_bit0_n_o, // write status
    output logic bus_status_bit1_n_o, // read status
    output logic [2:0] addr_o, // address 2..0
    output logic dec_o, // upper decode hit
    output logic [7:0] dat_o // write data
);
    // ----
    // bus cycles
    // ----
    // one cycle held six edges; released data is inverted so it never looks held
    task automatic cyc(input logic rd, input logic mem, input logic [2:0] a, input logic dec, input logic [7:0] d);
        @(negedge clk_i);
        cmd_n_o = 1'b0;
        mem_io_o = mem;
        bus_status_bit1_n_o = ~rd;
        bus_status_bit0_n_o = rd;
        addr_o = a;
        dec_o = dec;
        if (!rd)
            dat_o = d;
        repeat (6) @(negedge clk_i);
        cmd_n_o = 1'b1;
        bus_status_bit0_n_o = 1'b1;
        bus_status_bit1_n_o = 1'b1;
        dat_o = ~dat_o;
        repeat (6) @(negedge clk_i);
    endtask
    // only this card is ever selected
    task automatic setup(input logic on);
        @(negedge clk_i);
        card_setup_select_n_o = ~on;
        repeat (4) @(negedge clk_i);
    endtask
    // idle bus at time zero
    initial
    begin
        card_setup_select_n_o = 1'b1;
        cmd_n_o = 1'b1;
        mem_io_o = 1'b0;
        bus_status_bit0_n_o = 1'b1;
        bus_status_bit1_n_o = 1'b1;
        addr_o = 3'h0;
        dec_o = 1'b0;
        dat_o = 8'h00;
    end
endmodule // asids_host
`default_nettype wire

// File: tb/adapter_setup_id_sequencer_bench.sv
// self-checking bench of the adapter setup id sequencer
`timescale 1ns/10ps
`default_nettype none
module adapter_setup_id_sequencer_bench;
    import asids_pkg::*;
    localparam logic [7:0] LO = 8'ha5; // arbitrary id byte
    localparam logic [7:0] HI = 8'h3e; // arbitrary id byte
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    wire logic sel_n, cmd_n, mio, wr_st_n, rd_st_n, dec;
    wire logic [2:0] adr;
    wire logic [7:0] din;
    logic [7:0] dout;
    logic oe_n, ena, oe_q;
    asids_state_t st;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'he412;
    logic [7:0] exp_q[$];
    logic [7:0] rnd;
    always #5 mclk_i = ~mclk_i;
    asids_host host (.clk_i(mclk_i), .card_setup_select_n_o(sel_n), .cmd_n_o(cmd_n), .mem_io_o(mio),
        .bus_status_bit0_n_o(wr_st_n), .bus_status_bit1_n_o(rd_st_n), .addr_o(adr), .dec_o(dec), .dat_o(din));
    asids_seq #(.ID_LO(LO), .ID_HI(HI)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .card_setup_select_n_i(sel_n),
        .cmd_n_i(cmd_n), .mem_io_i(mio), .bus_status_bit0_n_i(wr_st_n), .bus_status_bit1_n_i(rd_st_n),
        .low_address_bits_i(adr), .decode_i(dec), .data_lines_i(din), .data_lines_o(dout),
        .data_lines_oe_n_o(oe_n), .adapter_enable_out_o(ena), .state_o(st));
    // ----
    // checking
    // ----
    task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // each start of a driven read takes the oldest note; a drive with none is a fault
    always @(negedge mclk_i)
    begin
        if (oe_n === 1'b0 && oe_q !== 1'b0)
            cmp("read data", exp_q.size() ? exp_q.pop_front() : 8'hxx, dout);
        oe_q = oe_n;
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            report_and_stop();
        end
    end
    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (3) @(negedge mclk_i);
        rst_n_i = 1'b1;
        cmp("state", 8'h00, {5'b0, st});
        cmp("enable", 8'h00, {7'b0, ena});
        host.cyc(1'b1, 1'b0, 3'h0, 1'b1, 8'h00);
        host.setup(1'b1);
        cmp("state", 8'h01, {5'b0, st});
        host.cyc(1'b1, 1'b0, 3'h1, 1'b1, 8'h00);
        host.cyc(1'b1, 1'b0, 3'h0, 1'b0, 8'h00);
        host.cyc(1'b1, 1'b1, 3'h0, 1'b1, 8'h00);
        exp_q.push_back(LO);
        host.cyc(1'b1, 1'b0, 3'h0, 1'b1, 8'h00);
        cmp("state", 8'h03, {5'b0, st});
        exp_q.push_back(HI);
        host.cyc(1'b1, 1'b0, 3'h1, 1'b1, 8'h00);
        cmp("state", 8'h05, {5'b0, st});
        // stray address, clear, set, then a write without decode
        for (int i = 0; i < 4; i++)
        begin
            rnd = $random(seed);
            rnd[0] = ~i[0];
            host.cyc(1'b0, 1'b0, (i == 0) ? 3'h3 : 3'h2, i != 3, rnd);
            cmp("enable", {7'b0, i[1]}, {7'b0, ena});
        end
        host.setup(1'b0);
        cmp("state", 8'h00, {5'b0, st});
        host.cyc(1'b0, 1'b0, 3'h2, 1'b1, 8'h00);
        cmp("enable", 8'h01, {7'b0, ena});
        @(negedge mclk_i);
        rst_n_i = 1'b0;
        @(negedge mclk_i);
        cmp("enable", 8'h00, {7'b0, ena});
        rst_n_i = 1'b1;
        host.setup(1'b1);
        exp_q.push_back(LO);
        host.cyc(1'b1, 1'b0, 3'h0, 1'b1, 8'h00);
        cmp("pending reads", 8'h00, 8'(exp_q.size()));
        report_and_stop();
    end
endmodule // adapter_setup_id_sequencer_bench
`default_nettype wire
